// *** rtl/scrs_top.sv ***
/*
 Volatile operating configuration register with its nonvolatile shadow,
 plus the two volatile limit registers that the copy command saves.
 Assumes a serial front end on clk presents decoded register accesses and
 the copy command, and that nonvolatile storage sits outside and takes a
 one-cycle write strobe with data.
*/
`timescale 1ns/1ps
`default_nettype none
module scrs_top (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire scrs_pkg::scrs_req_s req,
    input  wire logic               copyCmd,
    input  wire logic [7:0]         nvConfigByte,
    output logic [15:0]             rdData_q,
    output logic                    rdValid_q,
    output scrs_pkg::scrs_cfg_s     cfg_q,
    output logic                    measureStart_q,
    output logic                    nvWrEn_q,
    output logic [7:0]              nvCfgData_q,
    output logic [15:0]             nvLimitLow_q,
    output logic [15:0]             nvLimitHigh_q,
    output logic                    loadPending_q
);

    logic [15:0] limitLow_q;
    logic [15:0] limitHigh_q;
    logic        cfgWr;
    logic        shutdownLoad;

    assign cfgWr        = req.wrEn && (req.ptr == scrs_pkg::PTR_CONFIG) && !loadPending_q;
    assign shutdownLoad = nvConfigByte[0];

    ////////////////////////////////////////////////////////////////////////
    // Load from shadow after reset release, then live writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loadPending_q <= 1'b1;
        end else begin
            loadPending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= scrs_pkg::CFG_RESET;
        end else if (loadPending_q) begin
            cfg_q <= nvConfigByte;                                   // see R3
            cfg_q.singleConversionRequest <= 1'b0;
        end else if (cfgWr) begin
            cfg_q <= req.wrData[15:8];                               // see R1 see R2 see R4
            // One-shot is a request, not a stored setting
            cfg_q.singleConversionRequest <= 1'b0;                   // see R7
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limitLow_q  <= scrs_pkg::LIMIT_RESET;
            limitHigh_q <= scrs_pkg::LIMIT_RESET;
        end else if (req.wrEn && !loadPending_q) begin
            if (req.ptr == scrs_pkg::PTR_LIMIT_LOW) begin
                limitLow_q <= req.wrData;
            end
            if (req.ptr == scrs_pkg::PTR_LIMIT_HIGH) begin
                limitHigh_q <= req.wrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement start requests
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            measureStart_q <= 1'b0;
        end else if (loadPending_q) begin
            measureStart_q <= shutdownLoad;                          // see R9
        end else begin
            measureStart_q <= cfgWr && req.wrData[15] && cfg_q.shutdownMode; // see R8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Copy volatile to nonvolatile
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nvWrEn_q      <= 1'b0;
            nvCfgData_q   <= scrs_pkg::CFG_RESET;
            nvLimitLow_q  <= scrs_pkg::LIMIT_RESET;
            nvLimitHigh_q <= scrs_pkg::LIMIT_RESET;
        end else begin
            nvWrEn_q <= copyCmd && !loadPending_q;                   // see R4
            if (copyCmd && !loadPending_q) begin
                nvCfgData_q   <= cfg_q;                              // see R5
                nvLimitLow_q  <= limitLow_q;                         // see R6
                nvLimitHigh_q <= limitHigh_q;                        // see R6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q  <= 16'h0000;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= req.rdEn;
            if (req.rdEn) begin
                case (req.ptr)
                    scrs_pkg::PTR_CONFIG:     rdData_q <= {cfg_q, scrs_pkg::RESERVED_READ}; // see R10
                    scrs_pkg::PTR_LIMIT_LOW:  rdData_q <= limitLow_q;
                    scrs_pkg::PTR_LIMIT_HIGH: rdData_q <= limitHigh_q;
                    default:                  rdData_q <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Sampled rst_b skips the release edge, at which the flops still took reset
    property p_load;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && loadPending_q) |=> (cfg_q == {1'b0, $past(nvConfigByte[6:0])}) && !loadPending_q;
    endproperty
    a_load: assert property (p_load) else $error("config not loaded from shadow"); // see R3

    property p_boot_measure;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && loadPending_q && shutdownLoad) |=> measureStart_q ##1 !measureStart_q;
    endproperty
    a_boot_measure: assert property (p_boot_measure) else $error("no boot measurement"); // see R9

    property p_one_shot;
        @(posedge clk) disable iff (!rst_b)
        (cfgWr && req.wrData[15]) |=> (measureStart_q == $past(cfg_q.shutdownMode));
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot start wrong"); // see R8

    property p_write;
        @(posedge clk) disable iff (!rst_b)
        cfgWr |=> (cfg_q[6:0] == $past(req.wrData[14:8])) && !cfg_q.singleConversionRequest;
    endproperty
    a_write: assert property (p_write) else $error("config write lost"); // see R1

    property p_no_nv_on_write;
        @(posedge clk) disable iff (!rst_b)
        (req.wrEn && !copyCmd) |=> !nvWrEn_q && $stable(nvCfgData_q);
    endproperty
    a_no_nv_on_write: assert property (p_no_nv_on_write) else $error("write touched shadow"); // see R4

    property p_copy_cfg;
        @(posedge clk) disable iff (!rst_b)
        (copyCmd && !loadPending_q) |=> nvWrEn_q && (nvCfgData_q == $past(cfg_q));
    endproperty
    a_copy_cfg: assert property (p_copy_cfg) else $error("copy lost config"); // see R5

    property p_copy_limits;
        @(posedge clk) disable iff (!rst_b)
        (copyCmd && !loadPending_q) |=>
            (nvLimitLow_q == $past(limitLow_q)) && (nvLimitHigh_q == $past(limitHigh_q));
    endproperty
    a_copy_limits: assert property (p_copy_limits) else $error("copy lost limits"); // see R6

    property p_reserved_read;
        @(posedge clk) disable iff (!rst_b)
        (req.rdEn && req.ptr == scrs_pkg::PTR_CONFIG) |=>
            rdValid_q && (rdData_q[7:0] == 8'h00) && (rdData_q[15:8] == $past(cfg_q));
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("config read wrong"); // see R10 see R2

    property p_one_shot_reads_zero;
        @(posedge clk) disable iff (!rst_b)
        rdValid_q |-> !($past(req.ptr) == scrs_pkg::PTR_CONFIG && rdData_q[15]);
    endproperty
    a_one_shot_reads_zero: assert property (p_one_shot_reads_zero) else $error("one-shot read as 1"); // see R7

    property p_no_start_awake;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && !loadPending_q && !cfg_q.shutdownMode) |=> !measureStart_q;
    endproperty
    a_no_start_awake: assert property (p_no_start_awake) else $error("start outside shutdown"); // see R8

    property p_cfg_hold;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && !loadPending_q && !cfgWr) |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write"); // see R1

    property p_read_valid;
        @(posedge clk) disable iff (!rst_b)
        rst_b |=> (rdValid_q == $past(req.rdEn));
    endproperty
    a_read_valid: assert property (p_read_valid) else $error("read valid wrong"); // see R1

    property p_limit_refused;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && loadPending_q) |=> $stable(limitLow_q) && $stable(limitHigh_q);
    endproperty
    a_limit_refused: assert property (p_limit_refused) else $error("limit written during load"); // see R3

    property p_limit_write;
        @(posedge clk) disable iff (!rst_b)
        (req.wrEn && !loadPending_q && req.ptr == scrs_pkg::PTR_LIMIT_LOW) |=> (limitLow_q == $past(req.wrData));
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("low limit write lost"); // see R6

    property p_limit_read;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && req.rdEn && req.ptr == scrs_pkg::PTR_LIMIT_HIGH) |=> (rdData_q == $past(limitHigh_q));
    endproperty
    a_limit_read: assert property (p_limit_read) else $error("high limit read wrong"); // see R6

    property p_copy_only_on_cmd;
        @(posedge clk) disable iff (!rst_b)
        !(copyCmd && !loadPending_q) |=> !nvWrEn_q && $stable(nvLimitLow_q) && $stable(nvLimitHigh_q);
    endproperty
    a_copy_only_on_cmd: assert property (p_copy_only_on_cmd) else $error("shadow written without copy"); // see R4

    property p_unmapped_read;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && req.rdEn && req.ptr > scrs_pkg::PTR_LIMIT_HIGH) |=> (rdData_q == 16'h0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // see R1

endmodule
`default_nettype wire

// *** shared/scrs_pkg.sv ***
/*
 Package for the sensor configuration register shadow: pointer values,
 field layout of the configuration byte and reset values.
 Assumes the serial front end decodes pointer and data bytes on clk.
*/
// Behaviour
// R1: Configuration register is a 16-bit location, readable and writable by the master.
// R2: Only the upper byte carries settings; the lower byte has no effect.
// R3: After reset, load the register from the nonvolatile configuration upper byte.
// R4: Writes change only live settings, never the nonvolatile copy.
// R5: Copy command stores the live configuration into the nonvolatile upper byte.
// R6: Copy command also stores both temperature limit registers into nonvolatile copies.
// R7: Upper byte holds one-shot at bit 15 (default 0), resolution, queue, polarity, modes.
// R8: Writing 1 to one-shot starts one measurement, only while in shutdown.
// R9: If the loaded configuration selects shutdown, measure once right after reset.
// R10: Reserved lower-byte bits read as zero; written values are discarded.
package scrs_pkg;

    localparam logic [7:0]  PTR_CONFIG     = 8'h01;
    localparam logic [7:0]  PTR_LIMIT_LOW  = 8'h02;
    localparam logic [7:0]  PTR_LIMIT_HIGH = 8'h03;

    localparam int          BIT_ONE_SHOT   = 7;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [15:0] LIMIT_RESET    = 16'h0000;
    localparam logic [7:0]  RESERVED_READ  = 8'h00;

    // Upper byte of the configuration register, bit 15 first
    typedef struct packed {
        logic       singleConversionRequest;
        logic [1:0] conversionResolutionField;
        logic [1:0] faultQueue;
        logic       alarmPolarity;
        logic       thermostatMode;
        logic       shutdownMode;
    } scrs_cfg_s;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] ptr;
        logic [15:0] wrData;
    } scrs_req_s;

endpackage

// *** verification/scrs_host.sv ***
/*
 Bus master model: presents decoded register accesses and copy commands.
 Assumes accesses are taken at the rising clk edge after they are raised.
*/
`timescale 1ns/1ps
`default_nettype none
module scrs_host (
    input  wire logic               clk,
    output var scrs_pkg::scrs_req_s req,
    output var logic                copyCmd
);
    initial begin
        req = '0;
        copyCmd = 1'b0;
    end
    // One access held for exactly one sampling edge
    task automatic acc(input logic w, input logic [7:0] p, input logic [15:0] d);
        @(posedge clk);
        req <= '{wrEn: w, rdEn: !w, ptr: p, wrData: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    task automatic copy();
        @(posedge clk);
        copyCmd <= 1'b1;
        @(posedge clk);
        copyCmd <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// *** verification/scrs_top_test.sv ***
/*
 Self-checking bench for the configuration shadow block.
 Assumes the host model drives requests; nonvolatile byte is driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module scrs_top_test;
    logic clk, rst_b, copyCmd, rdValid_q, measureStart_q, nvWrEn_q, loadPending_q;
    logic [7:0] nvConfigByte, nvCfgData_q;
    logic [15:0] rdData_q, nvLimitLow_q, nvLimitHigh_q;
    scrs_pkg::scrs_req_s req;
    scrs_pkg::scrs_cfg_s cfg_q;
    int err_total, samples_checked, cycles;
    scrs_top u_scrs_top (.clk(clk), .rst_b(rst_b), .req(req), .copyCmd(copyCmd),
        .nvConfigByte(nvConfigByte), .rdData_q(rdData_q), .rdValid_q(rdValid_q), .cfg_q(cfg_q),
        .measureStart_q(measureStart_q), .nvWrEn_q(nvWrEn_q), .nvCfgData_q(nvCfgData_q),
        .nvLimitLow_q(nvLimitLow_q), .nvLimitHigh_q(nvLimitHigh_q), .loadPending_q(loadPending_q));
    scrs_host u_scrs_host (.clk(clk), .req(req), .copyCmd(copyCmd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_load();
        repeat (4) @(posedge clk);
        chk({15'h0, loadPending_q}, 16'h0001);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk({8'h00, cfg_q}, 16'h0001);
        chk({15'h0, loadPending_q}, 16'h0000);
        chk({15'h0, measureStart_q}, 16'h0001);
        $display("load test done");
    endtask
    task automatic t_write();
        u_scrs_host.acc(1'b1, scrs_pkg::PTR_CONFIG, 16'hf5ab);
        chk({8'h00, cfg_q}, 16'h0075);
        chk({14'h0, measureStart_q, nvWrEn_q}, 16'h0002);
        u_scrs_host.acc(1'b0, scrs_pkg::PTR_CONFIG, 16'h0000);
        chk({15'h0, rdValid_q}, 16'h0001);
        chk(rdData_q, 16'h7500);
        u_scrs_host.acc(1'b1, scrs_pkg::PTR_CONFIG, 16'h0600);
        u_scrs_host.acc(1'b1, scrs_pkg::PTR_CONFIG, 16'h8000);
        chk({15'h0, measureStart_q}, 16'h0000);
        u_scrs_host.acc(1'b0, 8'h7e, 16'h0000);
        chk(rdData_q, 16'h0000);
        $display("write test done");
    endtask
    task automatic t_copy();
        u_scrs_host.acc(1'b1, scrs_pkg::PTR_CONFIG, 16'h4a00);
        u_scrs_host.acc(1'b1, scrs_pkg::PTR_LIMIT_LOW, 16'h1940);
        u_scrs_host.acc(1'b1, scrs_pkg::PTR_LIMIT_HIGH, 16'h7d00);
        u_scrs_host.copy();
        chk({15'h0, nvWrEn_q}, 16'h0001);
        chk({8'h00, nvCfgData_q}, 16'h004a);
        chk(nvLimitLow_q, 16'h1940);
        chk(nvLimitHigh_q, 16'h7d00);
        @(posedge clk);
        #1;
        chk({15'h0, nvWrEn_q}, 16'h0000);
        u_scrs_host.acc(1'b0, scrs_pkg::PTR_LIMIT_HIGH, 16'h0000);
        chk(rdData_q, 16'h7d00);
        u_scrs_host.acc(1'b0, scrs_pkg::PTR_LIMIT_LOW, 16'h0000);
        chk(rdData_q, 16'h1940);
        $display("copy test done");
    endtask
    task automatic t_reload();
        @(posedge clk);
        rst_b <= 1'b0;
        nvConfigByte <= 8'h3c;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk({8'h00, cfg_q}, 16'h003c);
        chk({15'h0, measureStart_q}, 16'h0000);
        chk({15'h0, nvWrEn_q}, 16'h0000);
        $display("reload test done");
    endtask
    initial begin
        rst_b = 1'b0;
        nvConfigByte = 8'h81;
        err_total = 0;
        samples_checked = 0;
        t_load();
        t_write();
        t_copy();
        t_reload();
        give_verdict();
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 400) begin
                err_total++;
                give_verdict();
            end
        end
    end
endmodule
`default_nettype wire
